// >>> include/tap_pkg.sv
// What this block does
// - tdi/tms in, tdo out, clk clocks all, tck edges act as enables
// - decode standard, test and vendor instructions
// - two user registers, configuration and readback access
// - scan works regardless, overrides mode selection
// - user instructions only after configuration done
// - fixed 32-bit device identifier readable serially
// - 32-bit user identifier loaded, readable serially
// - per-pin pull-up, pull-down or none, pull-up default
// - instruction register is six bits
// - no test-reset pin, reset via tms
`default_nettype none
package tap_pkg;
  // -------------------------------------------------------------
  // register widths
  // -------------------------------------------------------------
  localparam int IR_LEN = 6;
  localparam int DR_LEN = 32;
  localparam int MODE_W = 3;
  localparam int SYNC_W = 6;
  // -------------------------------------------------------------
  // instruction opcodes
  // -------------------------------------------------------------
  localparam logic [5:0] OP_EXTEST = 6'h00;
  localparam logic [5:0] OP_SAMPLE = 6'h01;
  localparam logic [5:0] OP_FIRST_USER_SCAN_REGISTER = 6'h02;
  localparam logic [5:0] OP_SECOND_USER_SCAN_REGISTER = 6'h03;
  localparam logic [5:0] OP_CFG_OUT = 6'h04;
  localparam logic [5:0] OP_CFG_IN = 6'h05;
  localparam logic [5:0] OP_INTEST = 6'h07;
  localparam logic [5:0] OP_USERCODE = 6'h08;
  localparam logic [5:0] OP_IDCODE = 6'h09;
  localparam logic [5:0] OP_HIGHZ = 6'h0a;
  localparam logic [5:0] OP_BYPASS = 6'h3f;
  // fixed low bits of the captured instruction word
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
  // -------------------------------------------------------------
  // mode and pull encodings, reset values
  // -------------------------------------------------------------
  localparam logic [2:0] MODE_SCAN = 3'h5;
  localparam logic [1:0] PULL_UP = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [31:0] USERCODE_RESET = 32'hffff_ffff;
  // -------------------------------------------------------------
  // controller states, standard codes
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_EX2DR = 4'h0, ST_EX1DR = 4'h1, ST_SHDR = 4'h2, ST_PADR = 4'h3,
    ST_SELIR = 4'h4, ST_UPDR = 4'h5, ST_CAPDR = 4'h6, ST_SELDR = 4'h7,
    ST_EX2IR = 4'h8, ST_EX1IR = 4'h9, ST_SHIR = 4'ha, ST_PAIR = 4'hb,
    ST_RTI = 4'hc, ST_UPIR = 4'hd, ST_CAPIR = 4'he, ST_TLR = 4'hf
  } tap_state_type;
endpackage : tap_pkg
`default_nettype wire

// >>> rtl/boundary_scan_tap_port.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_port #(
  parameter int BSR_LEN = 16,
  parameter logic [31:0] DEVICE_ID = 32'h0000_0001 // arbitrary value, bit 0 set
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [7:0] pull_cfg,
  output logic [3:0] pull_up,
  output logic [3:0] pull_down,
  input wire logic cfg_done,
  input wire logic usercode_load,
  input wire logic [31:0] user_identifier_option,
  input wire logic [2:0] mode_sel,
  output logic [2:0] mode_out,
  output logic bscan_active,
  input wire logic [BSR_LEN-1:0] pin_in,
  output logic [BSR_LEN-1:0] pin_out,
  output logic pin_drive,
  output logic pin_highz,
  output logic core_isolate,
  output logic [1:0] user_sel,
  output logic dr_capture,
  output logic dr_shift_en,
  output logic dr_update,
  output logic scan_tdi,
  input wire logic first_user_scan_register_tdo,
  input wire logic second_user_scan_register_tdo,
  output logic cfg_in_sel,
  output logic cfg_out_sel,
  input wire logic cfg_rdata
);
  // ---------------------------------------------------------------
  // pin synchronisers and tck edge detect
  // ---------------------------------------------------------------
  logic [5:0] sync_w; // {mode_sel, tdi, tms, tck} after two flops
  logic tck_s, tms_s, tdi_s;
  logic [2:0] mode_s;
  logic tck_d_reg; // previous synced tck
  logic tck_rise, tck_fall;

  tap_sync #(.WIDTH(tap_pkg::SYNC_W)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({mode_sel, tdi, tms, tck}),
    .sync_out(sync_w)
  );
  assign tck_s = sync_w[0];
  assign tms_s = sync_w[1];
  assign tdi_s = sync_w[2];
  assign mode_s = sync_w[5:3];
  // tck is slow against clk, so its edges become one-cycle enables
  assign tck_rise = tck_s & ~tck_d_reg;
  assign tck_fall = ~tck_s & tck_d_reg;

  // ---------------------------------------------------------------
  // core state
  // ---------------------------------------------------------------
  tap_pkg::tap_state_type state_reg, state_next;
  logic [5:0] ir_shift_reg, ir_shift_next; // instruction shift stage
  logic [5:0] ir_reg, ir_next; // active instruction
  logic [31:0] dr_shift_reg, dr_shift_next; // id, usercode, bypass
  logic [BSR_LEN-1:0] bsr_shift_reg, bsr_shift_next;
  logic [31:0] usercode_reg, usercode_next;
  logic [2:0] tms_ones_reg, tms_ones_next; // helper for reset check

  // instruction decode
  logic sel_bsr, sel_id, sel_uc, sel_u1, sel_u2, sel_cin, sel_cout, sel_byp;
  logic dr_out; // serial bit of the selected data path

  always_comb begin
    // user paths fall back to bypass until configured
    sel_bsr = (ir_reg == tap_pkg::OP_EXTEST) || (ir_reg == tap_pkg::OP_INTEST)
              || (ir_reg == tap_pkg::OP_SAMPLE);
    sel_id = (ir_reg == tap_pkg::OP_IDCODE);
    sel_uc = (ir_reg == tap_pkg::OP_USERCODE);
    sel_u1 = (ir_reg == tap_pkg::OP_FIRST_USER_SCAN_REGISTER) && cfg_done;
    sel_u2 = (ir_reg == tap_pkg::OP_SECOND_USER_SCAN_REGISTER) && cfg_done;
    sel_cin = (ir_reg == tap_pkg::OP_CFG_IN);
    sel_cout = (ir_reg == tap_pkg::OP_CFG_OUT);
    // highz, bypass and unknown opcodes all use the single stage
    sel_byp = !(sel_bsr || sel_id || sel_uc || sel_u1 || sel_u2 || sel_cout);
  end

  // serial output mux
  always_comb begin
    if (sel_bsr) begin
      dr_out = bsr_shift_reg[0];
    end else if (sel_u1) begin
      dr_out = first_user_scan_register_tdo;
    end else if (sel_u2) begin
      dr_out = second_user_scan_register_tdo;
    end else if (sel_cout) begin
      dr_out = cfg_rdata;
    end else begin
      dr_out = dr_shift_reg[0];
    end
  end

  // controller and shift paths, advanced only on tck edges
  always_comb begin
    state_next = state_reg;
    ir_shift_next = ir_shift_reg;
    ir_next = ir_reg;
    dr_shift_next = dr_shift_reg;
    bsr_shift_next = bsr_shift_reg;
    usercode_next = usercode_reg;
    tms_ones_next = tms_ones_reg;
    if (usercode_load) begin
      usercode_next = user_identifier_option;
    end
    if (tck_rise) begin
      if (tms_s) begin
        tms_ones_next = (tms_ones_reg == 3'h5) ? 3'h5 : tms_ones_reg + 3'h1;
      end else begin
        tms_ones_next = 3'h0;
      end
      // sixteen states, tms sampled on rising tck
      case (state_reg)
        tap_pkg::ST_TLR: state_next = tms_s ? tap_pkg::ST_TLR : tap_pkg::ST_RTI;
        tap_pkg::ST_RTI: state_next = tms_s ? tap_pkg::ST_SELDR : tap_pkg::ST_RTI;
        tap_pkg::ST_SELDR: state_next = tms_s ? tap_pkg::ST_SELIR : tap_pkg::ST_CAPDR;
        tap_pkg::ST_CAPDR: state_next = tms_s ? tap_pkg::ST_EX1DR : tap_pkg::ST_SHDR;
        tap_pkg::ST_SHDR: state_next = tms_s ? tap_pkg::ST_EX1DR : tap_pkg::ST_SHDR;
        tap_pkg::ST_EX1DR: state_next = tms_s ? tap_pkg::ST_UPDR : tap_pkg::ST_PADR;
        tap_pkg::ST_PADR: state_next = tms_s ? tap_pkg::ST_EX2DR : tap_pkg::ST_PADR;
        tap_pkg::ST_EX2DR: state_next = tms_s ? tap_pkg::ST_UPDR : tap_pkg::ST_SHDR;
        tap_pkg::ST_UPDR: state_next = tms_s ? tap_pkg::ST_SELDR : tap_pkg::ST_RTI;
        tap_pkg::ST_SELIR: state_next = tms_s ? tap_pkg::ST_TLR : tap_pkg::ST_CAPIR;
        tap_pkg::ST_CAPIR: state_next = tms_s ? tap_pkg::ST_EX1IR : tap_pkg::ST_SHIR;
        tap_pkg::ST_SHIR: state_next = tms_s ? tap_pkg::ST_EX1IR : tap_pkg::ST_SHIR;
        tap_pkg::ST_EX1IR: state_next = tms_s ? tap_pkg::ST_UPIR : tap_pkg::ST_PAIR;
        tap_pkg::ST_PAIR: state_next = tms_s ? tap_pkg::ST_EX2IR : tap_pkg::ST_PAIR;
        tap_pkg::ST_EX2IR: state_next = tms_s ? tap_pkg::ST_UPIR : tap_pkg::ST_SHIR;
        tap_pkg::ST_UPIR: state_next = tms_s ? tap_pkg::ST_SELDR : tap_pkg::ST_RTI;
        default: state_next = tap_pkg::ST_TLR;
      endcase
      if (state_reg == tap_pkg::ST_CAPIR) begin
        ir_shift_next = {3'h0, cfg_done, tap_pkg::IR_CAPTURE_LOW};
      end else if (state_reg == tap_pkg::ST_SHIR) begin
        ir_shift_next = {tdi_s, ir_shift_reg[5:1]};
      end
      if (state_reg == tap_pkg::ST_CAPDR) begin
        if (sel_id) begin
          dr_shift_next = DEVICE_ID;
        end else if (sel_uc) begin
          dr_shift_next = usercode_reg;
        end else begin
          dr_shift_next = 32'h0000_0000;
        end
        if (sel_bsr) begin
          bsr_shift_next = pin_in;
        end
      end else if (state_reg == tap_pkg::ST_SHDR) begin
        if (sel_id || sel_uc) begin
          dr_shift_next = {tdi_s, dr_shift_reg[31:1]};
        end else begin
          dr_shift_next = {31'h0, tdi_s};
        end
        if (sel_bsr) begin
          bsr_shift_next = {tdi_s, bsr_shift_reg[BSR_LEN-1:1]};
        end
      end
      // only tms sequencing returns the logic to reset
      if (state_next == tap_pkg::ST_TLR) begin
        ir_next = tap_pkg::OP_IDCODE;
      end
    end
    // instruction takes effect on falling tck in update-ir
    if (tck_fall && state_reg == tap_pkg::ST_UPIR) begin
      ir_next = ir_shift_reg;
    end
  end

  // core registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= tap_pkg::ST_TLR;
      ir_shift_reg <= 6'h00;
      ir_reg <= tap_pkg::OP_IDCODE;
      dr_shift_reg <= 32'h0000_0000;
      bsr_shift_reg <= '0;
      usercode_reg <= tap_pkg::USERCODE_RESET;
      tms_ones_reg <= 3'h0;
      tck_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ir_shift_reg <= ir_shift_next;
      ir_reg <= ir_next;
      dr_shift_reg <= dr_shift_next;
      bsr_shift_reg <= bsr_shift_next;
      usercode_reg <= usercode_next;
      tms_ones_reg <= tms_ones_next;
      tck_d_reg <= tck_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs: tdo, pins, strobes, pulls
  // ---------------------------------------------------------------
  logic tdo_next, tdo_oe_next;
  logic [BSR_LEN-1:0] pin_out_next;
  logic [3:0] pull_up_next, pull_down_next;
  logic cap_next, sh_next, upd_next;
  logic [1:0] pcode;

  always_comb begin
    tdo_next = tdo;
    tdo_oe_next = tdo_oe;
    pin_out_next = pin_out;
    cap_next = tck_rise && (state_reg == tap_pkg::ST_CAPDR);
    sh_next = tck_rise && (state_reg == tap_pkg::ST_SHDR);
    upd_next = tck_fall && (state_reg == tap_pkg::ST_UPDR);
    // tdo moves only on falling tck
    if (tck_fall) begin
      tdo_oe_next = (state_reg == tap_pkg::ST_SHIR) || (state_reg == tap_pkg::ST_SHDR);
      if (state_reg == tap_pkg::ST_SHIR) begin
        tdo_next = ir_shift_reg[0];
      end else if (state_reg == tap_pkg::ST_SHDR) begin
        tdo_next = dr_out;
      end
    end
    if (upd_next && sel_bsr) begin
      pin_out_next = bsr_shift_reg;
    end
    // code 0 is pull-up, the power-on default
    for (int i = 0; i < 4; i++) begin
      pcode = pull_cfg[2*i +: 2];
      pull_up_next[i] = (pcode == tap_pkg::PULL_UP);
      pull_down_next[i] = (pcode == tap_pkg::PULL_DOWN);
    end
  end

  // output registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      pin_out <= '0;
      pull_up <= 4'hf;
      pull_down <= 4'h0;
      dr_capture <= 1'b0;
      dr_shift_en <= 1'b0;
      dr_update <= 1'b0;
    end else begin
      tdo <= tdo_next;
      tdo_oe <= tdo_oe_next;
      pin_out <= pin_out_next;
      pull_up <= pull_up_next;
      pull_down <= pull_down_next;
      dr_capture <= cap_next;
      dr_shift_en <= sh_next;
      dr_update <= upd_next;
    end
  end

  // test instructions take the pins away from the selected mode
  assign pin_drive = (ir_reg == tap_pkg::OP_EXTEST);
  assign core_isolate = (ir_reg == tap_pkg::OP_INTEST);
  assign pin_highz = (ir_reg == tap_pkg::OP_HIGHZ);
  assign cfg_in_sel = sel_cin;
  assign cfg_out_sel = sel_cout;
  assign user_sel = {sel_u2, sel_u1};
  assign scan_tdi = tdi_s;
  assign bscan_active = pin_drive | core_isolate | pin_highz | sel_cin | sel_cout;
  assign mode_out = bscan_active ? tap_pkg::MODE_SCAN : mode_s;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_cap_ir;
    tck_rise && (state_reg == tap_pkg::ST_CAPIR);
  endsequence
  sequence s_cap_dr;
    tck_rise && (state_reg == tap_pkg::ST_CAPDR);
  endsequence
  sequence s_shift_dr;
    tck_rise && (state_reg == tap_pkg::ST_SHDR);
  endsequence

  a_tms_reset: assert property (tms_ones_reg == 3'h5 |-> state_reg == tap_pkg::ST_TLR)
    else $error("five tms ones did not reach reset state");
  a_tdo_on_fall: assert property ($changed(tdo) |-> $past(tck_fall))
    else $error("tdo changed away from a falling tck");
  a_ir_capture: assert property (s_cap_ir |=> ir_shift_reg[1:0] == 2'h1)
    else $error("instruction capture pattern wrong");
  a_bypass_zero: assert property (s_cap_dr ##0 sel_byp |=> dr_shift_reg[0] == 1'b0)
    else $error("bypass stage did not capture zero");
  a_id_capture: assert property (s_cap_dr ##0 sel_id |=> dr_shift_reg == DEVICE_ID)
    else $error("device identifier not captured");
  a_uc_capture: assert property (s_cap_dr ##0 sel_uc |=> dr_shift_reg == $past(usercode_reg))
    else $error("user identifier not captured");
  a_shift_in: assert property (s_shift_dr ##0 sel_id |=> dr_shift_reg[31] == $past(tdi_s))
    else $error("tdi not shifted into data path");
  a_user_gated: assert property (user_sel != 2'h0 |-> cfg_done)
    else $error("user register selected before configuration");
  a_mode_override: assert property (bscan_active |-> mode_out == tap_pkg::MODE_SCAN)
    else $error("scan did not override mode selection");
  a_pull_default: assert property (pull_cfg[1:0] == 2'h0 |=> pull_up[0] && !pull_down[0])
    else $error("default pull-up not applied");
endmodule : boundary_scan_tap_port
`default_nettype wire

// >>> rtl/tap_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// two-flop synchroniser for pin inputs
// ---------------------------------------------------------------
module tap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg; // first stage, read only by second
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  // next values: plain shift
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : tap_sync
`default_nettype wire

// >>> verif/boundary_scan_tap_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_port_bench;
  // ---------------------------------------------------------------
  // settings and signals
  // ---------------------------------------------------------------
  localparam logic [31:0] DEV_ID = 32'h8a5c_3e71; // arbitrary value, bit 0 set
  localparam int LIMIT = 20000; // clk cycles, about five times the run
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, bscan_active, pin_drive, pin_highz, core_isolate;
  logic cfg_in_sel, cfg_out_sel, cfg_done, usercode_load, u1_tdo, u2_tdo, cfg_rdata;
  logic [7:0] pull_cfg;
  logic [3:0] pull_up, pull_down;
  logic [2:0] mode_sel, mode_out;
  logic [1:0] user_sel;
  logic [15:0] pin_in, pin_out;
  logic [31:0] uid, dout;
  logic [5:0] cap;
  logic dr_capture, dr_shift_en, dr_update, scan_tdi;
  int n_cap = 0; // capture strobes seen since reset
  int n_sh = 0; // shift strobes seen since reset
  int n_upd = 0; // update strobes seen since reset
  int compares = 0;
  int n_mismatch = 0;
  int cycles = 0;
  // the released tdo pin settles to its pull level; with no pull it floats
  // away from the last driven value, so a late sample cannot pass by luck
  wire logic tdo_wire = tdo_oe ? tdo : pull_up[3] ? 1'b1 : pull_down[3] ? 1'b0 : ~tdo;
  // ---------------------------------------------------------------
  // clock, design and far side
  // ---------------------------------------------------------------
  always #2.5 clk = ~clk;
  boundary_scan_tap_port #(.BSR_LEN(16), .DEVICE_ID(DEV_ID)) u_dut (
    .clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pull_cfg(pull_cfg), .pull_up(pull_up), .pull_down(pull_down),
    .cfg_done(cfg_done), .usercode_load(usercode_load), .user_identifier_option(uid),
    .mode_sel(mode_sel), .mode_out(mode_out), .bscan_active(bscan_active),
    .pin_in(pin_in), .pin_out(pin_out), .pin_drive(pin_drive), .pin_highz(pin_highz),
    .core_isolate(core_isolate), .user_sel(user_sel), .dr_capture(dr_capture),
    .dr_shift_en(dr_shift_en), .dr_update(dr_update), .scan_tdi(scan_tdi),
    .first_user_scan_register_tdo(u1_tdo),
    .second_user_scan_register_tdo(u2_tdo), .cfg_in_sel(cfg_in_sel),
    .cfg_out_sel(cfg_out_sel), .cfg_rdata(cfg_rdata)
  );
  tap_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_wire));
  // strobe pulses are only one clk wide, so they are counted here and a
  // scenario compares the growth of each count over a whole scan
  always @(posedge clk) begin
    n_cap <= n_cap + int'(dr_capture);
    n_sh <= n_sh + int'(dr_shift_en);
    n_upd <= n_upd + int'(dr_update);
  end
  // ---------------------------------------------------------------
  // comparison, closing report and hang guard
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // a stuck handshake would otherwise hang the run for ever
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // reset state, then identifier read with the reset instruction
  task automatic test_idcode();
    check("pull_up", 32'h0000_000f, pull_up);
    check("pull_down", 32'h0000_0000, pull_down);
    check("tdo_oe idle", 32'h0000_0000, tdo_oe);
    // the controller rests in test-logic-reset; scans start from idle
    u_host.reset_link();
    u_host.shift_dr(32, 32'h0000_0000, dout);
    check("idcode", DEV_ID, dout);
    $display("test idcode done");
  endtask : test_idcode
  // per-pin pull codes: up, down, none, down
  task automatic test_pull();
    @(posedge clk);
    #1;
    pull_cfg = 8'h64;
    repeat (2) @(posedge clk);
    check("pull_up cfg", 32'h0000_0001, pull_up);
    check("pull_down cfg", 32'h0000_000a, pull_down);
    $display("test pull done");
  endtask : test_pull
  // one-stage path that captures zero; bit 7 of the pattern falls off
  task automatic test_bypass(input logic [5:0] op);
    u_host.shift_ir(op, cap);
    check("ir capture", {29'h0, cfg_done, 2'h1}, cap);
    u_host.shift_dr(8, 32'h0000_00b5, dout);
    check("bypass data", 32'h0000_006a, dout);
    check("user_sel", 32'h0000_0000, user_sel);
    $display("test bypass %h done", op);
  endtask : test_bypass
  // user identifier reads its reset value, then the loaded option
  task automatic test_usercode();
    u_host.shift_ir(tap_pkg::OP_USERCODE, cap);
    u_host.shift_dr(32, 32'h0000_0000, dout);
    check("usercode reset", tap_pkg::USERCODE_RESET, dout);
    @(posedge clk);
    #1;
    uid = 32'h1357_9bdf;
    usercode_load = 1'b1;
    @(posedge clk);
    #1;
    usercode_load = 1'b0;
    uid = 32'h0000_0000;
    u_host.shift_dr(32, 32'h0000_0000, dout);
    check("usercode loaded", 32'h1357_9bdf, dout);
    $display("test usercode done");
  endtask : test_usercode
  // after configuration both user registers are routed to tdo
  task automatic test_user_regs();
    int cap0, sh0, upd0;
    @(posedge clk);
    #1;
    cfg_done = 1'b1;
    u_host.shift_ir(tap_pkg::OP_FIRST_USER_SCAN_REGISTER, cap);
    check("ir capture done", 32'h0000_0005, cap);
    check("user_sel 1", 32'h0000_0001, user_sel);
    cap0 = n_cap;
    sh0 = n_sh;
    upd0 = n_upd;
    u_host.shift_dr(8, 32'h0000_0000, dout);
    check("first_user_scan_register data", 32'h0000_00ff, dout);
    check("capture strobes", 32'h0000_0001, n_cap - cap0);
    check("shift strobes", 32'h0000_0008, n_sh - sh0);
    check("update strobes", 32'h0000_0001, n_upd - upd0);
    u_host.shift_ir(tap_pkg::OP_SECOND_USER_SCAN_REGISTER, cap);
    check("user_sel 2", 32'h0000_0002, user_sel);
    u_host.shift_dr(8, 32'h0000_00ff, dout);
    check("second_user_scan_register data", 32'h0000_0000, dout);
    $display("test user registers done");
  endtask : test_user_regs
  // sample and preload, then drive the preloaded value out
  task automatic test_boundary();
    u_host.shift_ir(tap_pkg::OP_SAMPLE, cap);
    check("sample override", 32'h0000_0000, bscan_active);
    u_host.shift_dr(16, 32'h0000_1234, dout);
    check("sampled pins", 32'h0000_a5c3, dout);
    u_host.shift_ir(tap_pkg::OP_EXTEST, cap);
    check("preloaded pins", 32'h0000_1234, pin_out);
    $display("test boundary done");
  endtask : test_boundary
  // every overriding instruction forces scan mode and its own flag
  task automatic test_modes();
    logic [5:0] ops [5];
    ops = '{tap_pkg::OP_EXTEST, tap_pkg::OP_INTEST, tap_pkg::OP_HIGHZ,
            tap_pkg::OP_CFG_IN, tap_pkg::OP_CFG_OUT};
    // the boundary test leaves an overriding instruction behind
    u_host.shift_ir(tap_pkg::OP_BYPASS, cap);
    check("mode pass", 32'h0000_0002, mode_out);
    for (int i = 0; i < 5; i++) begin
      u_host.shift_ir(ops[i], cap);
      check("bscan_active", 32'h0000_0001, bscan_active);
      check("mode_out", tap_pkg::MODE_SCAN, mode_out);
      check("flags", 5'b10000 >> i,
            {pin_drive, core_isolate, pin_highz, cfg_in_sel, cfg_out_sel});
    end
    $display("test modes done");
  endtask : test_modes
  // tms sequencing alone restores the identifier instruction
  task automatic test_tms_reset();
    u_host.reset_link();
    check("mode after reset", 32'h0000_0002, mode_out);
    check("scan_tdi", 32'h0000_0001, scan_tdi);
    u_host.shift_dr(32, 32'h0000_0000, dout);
    check("idcode after reset", DEV_ID, dout);
    $display("test tms reset done");
  endtask : test_tms_reset
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    pull_cfg = 8'h00;
    cfg_done = 1'b0;
    usercode_load = 1'b0;
    uid = 32'h0000_0000;
    mode_sel = 3'h2;
    pin_in = 16'ha5c3;
    u1_tdo = 1'b1;
    u2_tdo = 1'b0;
    cfg_rdata = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    test_idcode();
    test_pull();
    u_host.reset_link();
    test_bypass(tap_pkg::OP_BYPASS);
    test_bypass(6'h3e);
    test_bypass(tap_pkg::OP_FIRST_USER_SCAN_REGISTER);
    test_usercode();
    test_user_regs();
    test_boundary();
    test_modes();
    test_tms_reset();
    stop_test();
  end
endmodule : boundary_scan_tap_port_bench
`default_nettype wire

// >>> verif/tap_host.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// test controller model: owns tck, tms, tdi and samples tdo
// ---------------------------------------------------------------
module tap_host (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo
);
  localparam realtime HALF = 24.0; // half of the 48 ns link period
  // tck rests low between frames, tdi rests at its pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one tck period; tms and tdi change at the fall, so they are settled
  // long before the rise; tdo is taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #(HALF);
    q = tdo;
    tck = 1'b1;
    #(HALF);
    tck = 1'b0;
  endtask : step
  // five high tms rises reach test-logic-reset from any state, then idle
  task automatic reset_link();
    logic q;
    for (int i = 0; i < 5; i++) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : reset_link
  // instruction load from idle, six bits lsb first; returns captured word
  task automatic shift_ir(input logic [5:0] op, output logic [5:0] cap);
    logic q;
    step(1'b1, 1'b1, q);
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < 6; i++) step(i == 5, op[i], cap[i]);
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : shift_ir
  // data scan of n bits from idle, lsb first, back to idle after update
  task automatic shift_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = 32'h0000_0000;
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : shift_dr
endmodule : tap_host
`default_nettype wire
